// ### design/spm_entry.sv
// Program-mode entry detector, command engine, word FIFO and config words
`timescale 1ns/1ps

// Word FIFO; depth must be a power of two so the pointers wrap
module spm_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] buf_q [DEPTH]; // Storage, no reset needed
   logic [PW-1:0] wr_q; // Write pointer
   logic [PW-1:0] rd_q; // Read pointer
   logic [PW:0] cnt_q; // Fill level
   logic push;
   logic pop;

   assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = buf_q[rd_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Storage write
   always_ff @(posedge mclk_i) begin
      if (push) begin
         buf_q[wr_q] <= in_data_i;
      end
   end

   // Pointers and level; flush drops everything at once
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (flush_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// Notes on behaviour
// - Entry: clear pulse, 32-bit key, clear held
// - Only key 4D434850h enters program mode
// - Key arrives most significant bit first
// - Data ignored until P19 and P7 elapse
// - Unused pins high impedance while mode active
// - Erased code locations read all ones
// - Blank check skips identifiers, config, unimplemented
// - Blank query answers blank or not blank
// - Row program writes one row per command
// - Config words occupy last four memory locations
// - Third word bit12 selects parallel port pins
// - First word bit5 selects reference voltage pins
// - First word bit11 selects reset target
// - Second word bits7:6 switching and monitor
// - Second word bits10:8 choose initial oscillator
// - First word bit7 enables watchdog
// - First word bit4 selects watchdog prescaler
// - First word bit13 clear protects memory
module spm_entry import spm_pkg::*; #(
   parameter int MEM_WORDS = 256,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic master_clear_pin_i,
   input wire logic prog_clock_pin_i,
   input wire logic prog_data_pin_i,
   output logic prog_data_o,
   output logic prog_data_oe_b_o,
   output logic prog_busy_o,
   output logic mode_active_o,
   output logic unused_io_hiz_o,
   output spm_cfg_t sys_cfg_o
);
   localparam int AW = $clog2(MEM_WORDS);
   localparam int CODE_WORDS = MEM_WORDS - SPM_CFG_SLOTS;
   localparam logic [23:0] CODE_END = 24'(CODE_WORDS);
   localparam logic [23:0] MEM_END = 24'(MEM_WORDS);
   localparam logic [15:0] HOLD_LOAD = 16'(SPM_HOLD_CYC - 1);

   logic [1:0] clr_sq; // Pin synchronisers
   logic [1:0] clk_sq;
   logic [1:0] dat_sq;
   logic clk_prev_q; // Previous synchronised clock level
   logic clr_s;
   logic clk_s;
   logic dat_s;
   logic clk_rise;
   spm_mode_t mode_q; // Entry state
   logic [31:0] key_q; // Key shifter
   logic [5:0] kcnt_q; // Key bits seen, saturates at 33
   logic key_ok;
   logic [15:0] hold_q; // Guard countdown after entry
   logic active;
   logic [23:0] rx_sh_q; // Receive shifter
   logic [4:0] rx_cnt_q;
   logic rx_vld_q; // Completed word waiting for the FIFO
   logic [23:0] rx_word_q;
   logic f_in_rdy;
   logic f_vld;
   logic f_pop;
   logic [23:0] f_dout;
   spm_eng_t e_q; // Command engine state
   logic [7:0] op_q;
   logic [23:0] idx_q; // Word index into memory
   logic [6:0] left_q; // Row words still to come
   logic blank_q;
   logic [23:0] rsp_q; // Answer to send
   logic [23:0] tx_sh_q; // Transmit shifter
   logic [4:0] tx_cnt_q;
   logic oe_b_q; // Low while the data pin is driven
   logic [23:0] mem_q [CODE_WORDS]; // Code memory
   logic [23:0] cfg_q [SPM_CFG_SLOTS]; // Configuration words
   logic [1:0] cfg_slot;
   logic protect;
   logic wr_any;
   logic wr_code;
   logic wr_cfg;
   logic [23:0] mem_rd;
   logic [23:0] read_word;
   spm_cfg_t cfg_d;
   logic last_idx;

   assign clr_s = clr_sq[1];
   assign clk_s = clk_sq[1];
   assign dat_s = dat_sq[1];
   assign clk_rise = clk_s && !clk_prev_q;
   assign key_ok = (kcnt_q == 6'h20) && (key_q == SPM_ENTRY_KEY);
   assign active = (mode_q == M_ACTIVE);

   // Two flops on every pin before any logic looks at it
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clr_sq <= 2'h0;
         clk_sq <= 2'h0;
         dat_sq <= 2'h0;
         clk_prev_q <= 1'b0;
      end else begin
         clr_sq <= {clr_sq[0], master_clear_pin_i};
         clk_sq <= {clk_sq[0], prog_clock_pin_i};
         dat_sq <= {dat_sq[0], prog_data_pin_i};
         clk_prev_q <= clk_s;
      end
   end

   // Entry sequence: high, low, key, high and held
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_q <= M_WAIT_HI;
      end else begin
         case (mode_q)
            M_WAIT_HI: begin
               if (clr_s) begin
                  mode_q <= M_WAIT_LO;
               end
            end
            M_WAIT_LO: begin
               if (!clr_s) begin
                  mode_q <= M_KEY;
               end
            end
            M_KEY: begin
               // A bad key counts as a fresh high pulse
               if (clr_s) begin
                  mode_q <= key_ok ? M_HOLD : M_WAIT_LO;
               end
            end
            M_HOLD: begin
               if (!clr_s) begin
                  mode_q <= M_WAIT_HI;
               end else if (hold_q == 16'h0000) begin
                  mode_q <= M_ACTIVE;
               end
            end
            M_ACTIVE: begin
               // Dropping master-clear leaves the mode
               if (!clr_s) begin
                  mode_q <= M_WAIT_HI;
               end
            end
            default: begin
               mode_q <= M_WAIT_HI;
            end
         endcase
      end
   end

   // Key shifter, first bit ends up at the top
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         key_q <= '0;
         kcnt_q <= '0;
      end else if (mode_q != M_KEY) begin
         key_q <= '0;
         kcnt_q <= '0;
      end else if (clk_rise) begin
         key_q <= {key_q[30:0], dat_s};
         // Saturate so that extra bits spoil the key
         if (kcnt_q != 6'h21) begin
            kcnt_q <= kcnt_q + 6'h01;
         end
      end
   end

   // Guard countdown; data-pin activity is ignored until it ends
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hold_q <= HOLD_LOAD;
      end else if (mode_q != M_HOLD) begin
         hold_q <= HOLD_LOAD;
      end else if (hold_q != 16'h0000) begin
         hold_q <= hold_q - 16'h0001;
      end
   end

   // Receiver: 24-bit words, only when active and not answering
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_sh_q <= '0;
         rx_cnt_q <= '0;
         rx_vld_q <= 1'b0;
         rx_word_q <= '0;
      end else if (!active) begin
         rx_cnt_q <= '0;
         rx_vld_q <= 1'b0;
      end else begin
         if (rx_vld_q && f_in_rdy) begin
            rx_vld_q <= 1'b0;
         end
         // A word landing while one still waits overwrites it
         if (clk_rise && oe_b_q) begin
            rx_sh_q <= {rx_sh_q[22:0], dat_s};
            if (rx_cnt_q == 5'h17) begin
               rx_cnt_q <= '0;
               rx_vld_q <= 1'b1;
               rx_word_q <= {rx_sh_q[22:0], dat_s};
            end else begin
               rx_cnt_q <= rx_cnt_q + 5'h01;
            end
         end
      end
   end

   // Buffer between pin receiver and the command engine
   spm_fifo #(.WIDTH(SPM_WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .flush_i(!active),
      .in_valid_i(rx_vld_q),
      .in_ready_o(f_in_rdy),
      .in_data_i(rx_word_q),
      .out_valid_o(f_vld),
      .out_ready_i(f_pop),
      .out_data_o(f_dout)
   );

   assign f_pop = f_vld && (e_q == E_CMD || e_q == E_ADDR || e_q == E_DATA);
   assign protect = !cfg_q[SPM_CFG_W1][SPM_W1_CP];
   assign cfg_slot = 2'(idx_q - CODE_END);
   assign mem_rd = mem_q[idx_q[AW-1:0]];
   assign last_idx = (idx_q == CODE_END - 24'h000001);
   assign wr_any = (e_q == E_DATA) && f_vld && !protect;
   assign wr_code = wr_any && (idx_q < CODE_END);
   assign wr_cfg = wr_any && (idx_q >= CODE_END) && (idx_q < MEM_END);

   // Readback; protected code and unimplemented space read zero
   always_comb begin
      read_word = '0;
      if (idx_q < CODE_END) begin
         read_word = protect ? '0 : mem_rd;
      end else if (idx_q < MEM_END) begin
         read_word = cfg_q[cfg_slot];
      end
   end

   // Command engine
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         e_q <= E_CMD;
         op_q <= '0;
         idx_q <= '0;
         left_q <= '0;
         blank_q <= 1'b0;
         rsp_q <= '0;
      end else if (!active) begin
         e_q <= E_CMD;
      end else begin
         case (e_q)
            E_CMD: begin
               if (f_vld) begin
                  op_q <= f_dout[23:16];
                  idx_q <= '0;
                  blank_q <= 1'b1;
                  case (f_dout[23:16])
                     SPM_OP_BLANK: e_q <= E_BLANK;
                     SPM_OP_ERASE: e_q <= E_ERASE;
                     SPM_OP_PROG, SPM_OP_READ: e_q <= E_ADDR;
                     default: e_q <= E_CMD; // Unknown words are dropped
                  endcase
               end
            end
            E_ADDR: begin
               if (f_vld) begin
                  idx_q <= {1'b0, f_dout[23:1]};
                  left_q <= 7'(SPM_ROW_WORDS - 1);
                  e_q <= (op_q == SPM_OP_PROG) ? E_DATA : E_READ;
               end
            end
            E_DATA: begin
               // One row per command, no special case at panel edges
               if (f_vld) begin
                  idx_q <= idx_q + 24'h000001;
                  if (left_q == 7'h00) begin
                     rsp_q <= SPM_RSP_ACK;
                     e_q <= E_TX;
                  end else begin
                     left_q <= left_q - 7'h01;
                  end
               end
            end
            E_READ: begin
               rsp_q <= read_word;
               e_q <= E_TX;
            end
            E_BLANK: begin
               // Scan covers code words only; config kept apart
               if (mem_rd != SPM_ERASED) begin
                  blank_q <= 1'b0;
               end
               if (last_idx) begin
                  rsp_q <= (blank_q && mem_rd == SPM_ERASED) ?
                     SPM_RSP_BLANK : SPM_RSP_NOTBLANK;
                  e_q <= E_TX;
               end else begin
                  idx_q <= idx_q + 24'h000001;
               end
            end
            E_ERASE: begin
               if (last_idx) begin
                  rsp_q <= SPM_RSP_ACK;
                  e_q <= E_TX;
               end else begin
                  idx_q <= idx_q + 24'h000001;
               end
            end
            E_TX: begin
               e_q <= E_WAIT;
            end
            E_WAIT: begin
               if (oe_b_q) begin
                  e_q <= E_CMD;
               end
            end
            default: begin
               e_q <= E_CMD;
            end
         endcase
      end
   end

   // Code memory writes; erase fills with ones
   always_ff @(posedge mclk_i) begin
      if (active && e_q == E_ERASE) begin
         mem_q[idx_q[AW-1:0]] <= SPM_ERASED;
      end else if (wr_code) begin
         mem_q[idx_q[AW-1:0]] <= f_dout;
      end
   end

   // Configuration words, erased state after reset
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_q <= '{default: SPM_ERASED};
      end else if (active && e_q == E_ERASE && last_idx) begin
         cfg_q <= '{default: SPM_ERASED};
      end else if (wr_cfg) begin
         cfg_q[cfg_slot] <= f_dout;
      end
   end

   // Transmitter: first bit out at load, shift on each clock rise
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_sh_q <= '0;
         tx_cnt_q <= '0;
         oe_b_q <= 1'b1;
      end else if (!active) begin
         oe_b_q <= 1'b1;
      end else if (e_q == E_TX) begin
         tx_sh_q <= rsp_q;
         tx_cnt_q <= 5'h18;
         oe_b_q <= 1'b0;
      end else if (!oe_b_q && clk_rise) begin
         tx_sh_q <= {tx_sh_q[22:0], 1'b0};
         tx_cnt_q <= tx_cnt_q - 5'h01;
         if (tx_cnt_q == 5'h01) begin
            oe_b_q <= 1'b1;
         end
      end
   end

   // Field decode of the configuration words
   always_comb begin
      cfg_d = '0;
      cfg_d.parallel_port_pin_map_sel =
         cfg_q[SPM_CFG_W3][SPM_W3_PMP];
      cfg_d.vref_location_sel = cfg_q[SPM_CFG_W1][SPM_W1_VREF];
      cfg_d.reset_to_debug = !cfg_q[SPM_CFG_W1][SPM_W1_DBG];
      cfg_d.clk_switch_en = !cfg_q[SPM_CFG_W2][SPM_W2_FCK_HI];
      cfg_d.fail_safe_mon_en = !cfg_q[SPM_CFG_W2][SPM_W2_FCK_HI] &&
         !cfg_q[SPM_CFG_W2][SPM_W2_FCK_LO];
      cfg_d.initial_osc_select =
         cfg_q[SPM_CFG_W2][SPM_W2_OSC_LO +: 3];
      cfg_d.osc_select_reserved = (cfg_q[SPM_CFG_W2][SPM_W2_OSC_LO +: 3]
         == SPM_OSC_RESERVED);
      cfg_d.watchdog_enable_cfg = cfg_q[SPM_CFG_W1][SPM_W1_WDTEN];
      cfg_d.watchdog_prescale_sel =
         cfg_q[SPM_CFG_W1][SPM_W1_WPRE];
      cfg_d.code_protect_cfg = protect;
   end

   // Registered outputs
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sys_cfg_o <= '0;
         prog_busy_o <= 1'b0;
         mode_active_o <= 1'b0;
         unused_io_hiz_o <= 1'b0;
      end else begin
         sys_cfg_o <= cfg_d;
         prog_busy_o <= !f_in_rdy || e_q == E_READ || e_q == E_BLANK ||
            e_q == E_ERASE || e_q == E_TX;
         mode_active_o <= active;
         unused_io_hiz_o <= active;
      end
   end

   assign prog_data_o = tx_sh_q[23];
   assign prog_data_oe_b_o = oe_b_q;

   AST_BAD_KEY: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == M_KEY && clr_s && !key_ok |=> mode_q == M_WAIT_LO)
      else $error("bad key did not return to waiting");
   AST_GOOD_KEY: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == M_KEY && clr_s && key_ok |=> mode_q == M_HOLD)
      else $error("valid key did not start guard time");
   AST_KEY_ORDER: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == M_KEY && clk_rise && !clr_s |=>
      key_q[0] == $past(dat_s) && key_q[31:1] == $past(key_q[30:0]))
      else $error("key not shifted in msb first");
   AST_GUARD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == M_HOLD && hold_q != 16'h0000 |=>
      !active && !rx_vld_q)
      else $error("mode active before guard time ended");
   AST_HIZ: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      active |=> unused_io_hiz_o && mode_active_o)
      else $error("unused pins not released in mode");
   AST_ERASE_ONES: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      active && e_q == E_ERASE |=>
      mem_q[$past(idx_q[AW-1:0])] == SPM_ERASED)
      else $error("erased word not all ones");
   AST_BLANK_RANGE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      e_q == E_BLANK |-> idx_q < CODE_END)
      else $error("blank scan left code space");
   AST_BLANK_ANS: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      active && e_q == E_BLANK && last_idx |=>
      (rsp_q == SPM_RSP_BLANK || rsp_q == SPM_RSP_NOTBLANK) ##1 !oe_b_q)
      else $error("blank query answer missing");
   AST_ROW_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      active && wr_code |=>
      mem_q[$past(idx_q[AW-1:0])] == $past(f_dout))
      else $error("row word not stored at its address");
   AST_FCK: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      cfg_q[SPM_CFG_W2][SPM_W2_FCK_HI] |=>
      !sys_cfg_o.clk_switch_en && !sys_cfg_o.fail_safe_mon_en)
      else $error("clock switching not disabled");
   AST_PROTECT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      !cfg_q[SPM_CFG_W1][SPM_W1_CP] |=> sys_cfg_o.code_protect_cfg)
      else $error("code protection not reported");
endmodule

// ### design/spm_pkg.sv
// Shared constants, types and encodings for the serial program-mode block
package spm_pkg;
   // Mode entry key, shifted in most significant bit first
   localparam logic [31:0] SPM_ENTRY_KEY = 32'h4D434850;
   localparam int SPM_KEY_BITS = 32;
   localparam int SPM_WORD_BITS = 24;
   // Guard times after the final master-clear rise, in ns
   localparam int SPM_T_P19_NS = 25;
   localparam int SPM_T_P7_NS = 500;
   localparam int SPM_CLK_MHZ = 40;
   // Least time, rounded up to whole cycles
   localparam int SPM_HOLD_CYC =
      ((SPM_T_P19_NS + SPM_T_P7_NS) * SPM_CLK_MHZ + 999) / 1000;
   // Row geometry: addresses step 80h, two address units per word
   localparam logic [23:0] SPM_ROW_ADDR_STEP = 24'h000080;
   localparam int SPM_ROW_WORDS = 32'(SPM_ROW_ADDR_STEP) / 2;
   // Erased locations read back as all ones
   localparam logic [23:0] SPM_ERASED = 24'hFFFFFF;
   // Configuration slots at the top of implemented memory
   localparam int SPM_CFG_SLOTS = 4;
   localparam int SPM_CFG_W3 = 1;
   localparam int SPM_CFG_W2 = 2;
   localparam int SPM_CFG_W1 = 3;
   // Field positions inside the configuration words
   localparam int SPM_W1_WPRE = 4;
   localparam int SPM_W1_VREF = 5;
   localparam int SPM_W1_WDTEN = 7;
   localparam int SPM_W1_DBG = 11;
   localparam int SPM_W1_CP = 13;
   localparam int SPM_W2_FCK_LO = 6;
   localparam int SPM_W2_FCK_HI = 7;
   localparam int SPM_W2_OSC_LO = 8;
   localparam int SPM_W3_PMP = 12;
   localparam logic [2:0] SPM_OSC_RESERVED = 3'h6;
   // Command opcodes, carried in bits 23:16 of the first word
   localparam logic [7:0] SPM_OP_READ = 8'h02;
   localparam logic [7:0] SPM_OP_ERASE = 8'h04;
   localparam logic [7:0] SPM_OP_PROG = 8'h05;
   localparam logic [7:0] SPM_OP_BLANK = 8'h0E;
   // Answer words
   localparam logic [23:0] SPM_RSP_ACK = 24'h0000A5;
   localparam logic [23:0] SPM_RSP_BLANK = 24'h0000B1;
   localparam logic [23:0] SPM_RSP_NOTBLANK = 24'h0000B0;
   // Entry and command engine states
   typedef enum logic [2:0] {
      M_WAIT_HI, M_WAIT_LO, M_KEY, M_HOLD, M_ACTIVE
   } spm_mode_t;
   typedef enum logic [2:0] {
      E_CMD, E_ADDR, E_DATA, E_READ, E_BLANK, E_ERASE, E_TX, E_WAIT
   } spm_eng_t;
   // Decoded configuration, presented to the rest of the chip
   typedef struct packed {
      logic parallel_port_pin_map_sel;
      logic vref_location_sel;
      logic reset_to_debug;
      logic clk_switch_en;
      logic fail_safe_mon_en;
      logic [2:0] initial_osc_select;
      logic osc_select_reserved;
      logic watchdog_enable_cfg;
      logic watchdog_prescale_sel;
      logic code_protect_cfg;
   } spm_cfg_t;
endpackage

// ### sim/spm_prog_model.sv
// Programmer model driving the clear, link clock and data pins
`timescale 1ns/1ps
module spm_prog_model #(
   parameter int P18_CYC = 4  // Entry gap in cycles, plain default
) (
   input wire logic mclk_i,
   input wire logic busy_i,
   input wire logic oe_b_i,
   input wire logic pin_i,
   output logic clr_o,
   output logic clk_o,
   output logic dat_o,
   output logic en_o
);
   // Idle: clear low, link clock still, data driven
   initial begin
      clr_o = 1'b0;
      clk_o = 1'b0;
      dat_o = 1'b0;
      en_o = 1'b1;
   end
   logic [7:0] app_id = 8'h00; // Firmware identifier, nothing loaded yet
   // Firmware counts as resident only when its identifier is CCh
   // Otherwise it is loaded first, which leaves CCh behind
   task automatic fw_ready();
      if (app_id != 8'hCC) app_id = 8'hCC;
   endtask
   task automatic gap(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // Each link clock level lasts 4 cycles so the synchroniser sees it
   task automatic bit_out(input logic b);
      dat_o <= b;
      gap(4);
      clk_o <= 1'b1;
      gap(4);
      clk_o <= 1'b0;
   endtask
   // Clear pulse, gap, key MSB first, clear held
   task automatic enter(input logic [31:0] key);
      clr_o <= 1'b1;
      gap(4);
      clr_o <= 1'b0;
      gap(P18_CYC);
      for (int i = 31; i >= 0; i--) bit_out(key[i]);
      gap(4);
      clr_o <= 1'b1;
   endtask
   // Word MSB first; waits while the device refuses
   task automatic send(input logic [23:0] w);
      for (int n = 0; n < 400 && busy_i !== 1'b0; n++) gap(1);
      for (int i = 23; i >= 0; i--) bit_out(w[i]);
   endtask
   // Release data, wait for the answer, sample before each rise
   task automatic recv(output logic [23:0] w);
      en_o <= 1'b0;
      for (int n = 0; n < 600 && oe_b_i !== 1'b0; n++) gap(1);
      for (int i = 23; i >= 0; i--) begin
         gap(4);
         w[i] = pin_i;
         clk_o <= 1'b1;
         gap(4);
         clk_o <= 1'b0;
      end
      en_o <= 1'b1;
   endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench for the program-mode entry block
`timescale 1ns/1ps
module testbench import spm_pkg::*;;
   localparam int MW = 128;  // Two rows reach the config slots
   localparam logic [23:0] RD = {SPM_OP_READ, 16'h0000};
   localparam logic [23:0] PG = {SPM_OP_PROG, 16'h0000};
   localparam logic [23:0] BQ = {SPM_OP_BLANK, 16'h0000};
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic clr_pin, link_clk, host_d, host_en, dev_d, oe_b, busy, mode, hiz;
   spm_cfg_t cfg;
   wire logic data_pin;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   // Released line shows the inverse of the last host bit
   assign data_pin = !oe_b ? dev_d : host_en ? host_d : ~host_d;
   always #12.5 mclk_i = ~mclk_i;
   spm_entry #(.MEM_WORDS(MW), .FIFO_DEPTH(8)) DUT (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .master_clear_pin_i(clr_pin),
      .prog_clock_pin_i(link_clk), .prog_data_pin_i(data_pin),
      .prog_data_o(dev_d), .prog_data_oe_b_o(oe_b), .prog_busy_o(busy),
      .mode_active_o(mode), .unused_io_hiz_o(hiz), .sys_cfg_o(cfg)
   );
   spm_prog_model pm (
      .mclk_i(mclk_i), .busy_i(busy), .oe_b_i(oe_b), .pin_i(data_pin),
      .clr_o(clr_pin), .clk_o(link_clk), .dat_o(host_d), .en_o(host_en)
   );
   task automatic close_out();
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Row data; last slots hold the config words, bit 15 kept clear
   function automatic logic [23:0] dat(input int k);
      if (k == MW - 1) return 24'h002000;
      if (k == MW - 2) return 24'h000640;
      if (k == MW - 3) return 24'h000000;
      return 24'h5A0000 | 24'(k);
   endfunction
   // One command, address word for reads, answer compared
   task automatic op(input logic [23:0] c, a, e);
      logic [23:0] w;
      pm.send(c);
      if (c == RD) pm.send(a);
      pm.recv(w);
      check(w, e);
   endtask
   // Reset state and erased decode of the config words
   task automatic t_reset();
      check({23'h0, mode}, 24'h000000);
      check({23'h0, hiz}, 24'h000000);
      check({23'h0, oe_b}, 24'h000001);
      check({12'h0, cfg}, 24'h000C76);
   endtask
   // Bit-reversed key and key off by one stay out of the mode
   task automatic t_key_bad();
      logic [31:0] bad [2];
      bad = '{32'h0A12C2B2, 32'h4D434851};
      foreach (bad[k]) begin
         pm.enter(bad[k]);
         repeat (40) @(posedge mclk_i);
         check({23'h0, mode}, 24'h000000);
         check({23'h0, hiz}, 24'h000000);
      end
   endtask
   // Right key: guard time passes first, then mode and idle pins
   task automatic t_key_good();
      pm.enter(SPM_ENTRY_KEY);
      repeat (20) @(posedge mclk_i);
      check({23'h0, mode}, 24'h000000);
      repeat (10) @(posedge mclk_i);
      check({23'h0, mode}, 24'h000001);
      check({23'h0, hiz}, 24'h000001);
      pm.fw_ready();
   endtask
   // Erase, blank query, erased reads, identifier region left out
   task automatic t_erase_blank();
      logic [23:0] w;
      op({SPM_OP_ERASE, 16'h0000}, 24'h000000, SPM_RSP_ACK);
      pm.send(BQ);
      // The scan of the code words keeps the engine busy for a while
      repeat (40) @(posedge mclk_i);
      check({23'h0, busy}, 24'h000001);
      pm.recv(w);
      check(w, SPM_RSP_BLANK);
      op(RD, 24'h000000, SPM_ERASED);
      op(RD, 24'h0000F6, SPM_ERASED);
      op(RD, 24'hFF0000, 24'h000000);
   endtask
   // Two rows 80h apart; the second one writes the config slots
   task automatic t_rows();
      logic [23:0] w;
      for (int r = 0; r < 2; r++) begin
         pm.send(PG);
         pm.send(24'(r) * SPM_ROW_ADDR_STEP);
         for (int i = 0; i < 64; i++) pm.send(dat(r * 64 + i));
         pm.recv(w);
         check(w, SPM_RSP_ACK);
      end
      op(RD, 24'h000080, dat(64));
      op(RD, 24'h00007E, dat(63));
      op(RD, 24'h0000FE, dat(MW - 1));
      op(BQ, 24'h000000, SPM_RSP_NOTBLANK);
      check({12'h0, cfg}, 24'h000368);
      check({21'h0, cfg.initial_osc_select}, 24'h000006);
      check({23'h0, cfg.watchdog_enable_cfg}, 24'h000000);
      check({23'h0, cfg.watchdog_prescale_sel}, 24'h000000);
      check({23'h0, cfg.code_protect_cfg}, 24'h000000);
   endtask
   // Clearing the protect bit hides code until an erase clears it
   task automatic t_protect();
      logic [23:0] w;
      pm.send(PG);
      pm.send(24'h0000FE);
      repeat (64) pm.send(24'h000000);
      pm.recv(w);
      check(w, SPM_RSP_ACK);
      check({23'h0, cfg.code_protect_cfg}, 24'h000001);
      op(RD, 24'h000080, 24'h000000);
      op({SPM_OP_ERASE, 16'h0000}, 24'h000000, SPM_RSP_ACK);
      op(RD, 24'h000080, SPM_ERASED);
      check({12'h0, cfg}, 24'h000C76);
   endtask
   // Hang guard, well above the expected run length
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 70000) begin
         failures++;
         close_out();
      end
   end
   // Main sequence after 6 cycles of reset
   initial begin
      repeat (6) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      t_reset();
      t_key_bad();
      t_key_good();
      t_erase_blank();
      t_rows();
      t_protect();
      close_out();
   end
endmodule
